// [hw/sbl_pkg.sv]
// constants and types shared by the serial binary load/unload engine
package sbl_pkg;
  localparam longint CLK_HZ = 100_000_000; // system clock rate
  localparam longint TIMEOUT_S = 60; // load byte timeout, seconds
  localparam longint TIMEOUT_CYC = TIMEOUT_S * CLK_HZ; // timeout in cycles
  localparam int TMR_W = 33; // timer width, holds timeout count
  localparam int LINE_MAX = 32; // command line buffer depth
  localparam int FIFO_DEPTH = 8; // receive fifo depth
  localparam int DIR_BIT = 31; // direction bit of the count
  localparam logic [7:0] CH_CR = 8'h0d; // carriage return
  localparam logic [7:0] CH_RUB = 8'h7f; // rubout
  localparam logic [7:0] CH_SP = 8'h20; // space separator
  localparam logic [7:0] CH_BANG = 8'h21; // comment character
  localparam logic [7:0] CH_X = 8'h58; // transfer command letter
  localparam logic [7:0] CH_XL = 8'h78; // lower-case form
  localparam logic [7:0] CH_0 = 8'h30; // digit zero
  localparam logic [7:0] CH_9 = 8'h39; // digit nine
  localparam logic [7:0] CH_A = 8'h41; // letter A
  localparam logic [7:0] CH_F = 8'h46; // letter F
  localparam logic [7:0] CH_AL = 8'h61; // letter a
  localparam logic [7:0] CH_FL = 8'h66; // letter f
  localparam logic [7:0] HEX_TEN = 8'h0a; // value of hex letter A
  localparam logic [7:0] CH_Q = 8'h3f; // error mark
  localparam logic [7:0] CH_LF = 8'h0a; // line feed
  localparam logic [7:0] CH_GT = 8'h3e; // prompt character
  localparam logic [2:0] MSG_ERR = 3'h0; // error text start
  localparam logic [2:0] MSG_PROMPT = 3'h3; // prompt text start
  localparam logic [2:0] MSG_LAST = 3'h5; // last message byte
  // received byte with its line error flag
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } sbl_rx_type;
  // memory byte request
  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [7:0] wdata;
  } sbl_mem_type;
  // engine states
  typedef enum logic [3:0] {
    S_CMD, S_PARSE, S_CKSUM, S_MSG, S_LD_RX, S_LD_WR, S_LD_SUM,
    S_UL_RD, S_UL_TX, S_UL_SUM
  } sbl_state_type;
  // whole engine state
  typedef struct packed {
    sbl_state_type st;
    logic [7:0] sum;
    logic [31:0] cnt;
    logic [5:0] len;
    logic [5:0] idx;
    logic [1:0] field;
    logic isX;
    logic comment;
    logic [TMR_W-1:0] tmr;
    logic err;
    logic goData;
    logic [2:0] msgIdx;
    logic [7:0] hold;
    logic txValid;
    logic [7:0] txData;
    sbl_mem_type mem;
  } sbl_regs_type;
endpackage

// [hw/sbl_engine.sv]
// receive fifo and binary load/unload engine for the console line
module sbl_fifo #(parameter int WIDTH = 9, parameter int DEPTH = 8) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int AW = $clog2(DEPTH);
  // fifo state: storage and pointers with wrap bit
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sbl_fifo_type;
  sbl_fifo_type cur, next_cur;
  logic full, empty;
  // honest flags from the pointers
  assign full = (cur.wp[AW] != cur.rp[AW]) && (cur.wp[AW-1:0] == cur.rp[AW-1:0]);
  assign empty = cur.wp == cur.rp;
  assign wrReady = !full;
  assign rdValid = !empty;
  assign rdData = cur.mem[cur.rp[AW-1:0]];
  // push and pop
  always_comb begin
    next_cur = cur;
    if (wrValid && !full) begin
      next_cur.mem[cur.wp[AW-1:0]] = wrData;
      next_cur.wp = cur.wp + 1'b1;
    end
    if (rdReady && !empty) begin
      next_cur.rp = cur.rp + 1'b1;
    end
  end
  // register, pointers cleared on reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

module sbl_engine #(parameter longint TIMEOUT_CYCLES = sbl_pkg::TIMEOUT_CYC,
  parameter int DEPTH = sbl_pkg::FIFO_DEPTH) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic rxValid,
  output logic rxReady,
  input wire sbl_pkg::sbl_rx_type rxByte,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  input wire logic lineHold,
  output logic flowCancel,
  output logic flowActive,
  output sbl_pkg::sbl_mem_type memOut,
  input wire logic memAck,
  input wire logic memErr,
  input wire logic [7:0] memRdata
);
  sbl_pkg::sbl_regs_type cur, next_cur;
  logic [7:0] lineBuf [sbl_pkg::LINE_MAX]; // command line characters
  logic fValid, pop, timedOut, bufWr;
  sbl_pkg::sbl_rx_type fByte;
  logic [7:0] c, s;
  // console line bytes only; buffer keeps full-rate bursts
  sbl_fifo #(.WIDTH($bits(sbl_pkg::sbl_rx_type)), .DEPTH(DEPTH)) rxFifo (
    .clk_sys(clk_sys), .reset_n(reset_n), .wrValid(rxValid), .wrReady(rxReady),
    .wrData(rxByte), .rdValid(fValid), .rdReady(pop), .rdData(fByte));
  assign txValid = cur.txValid;
  assign txData = cur.txData;
  assign memOut = cur.mem;
  assign timedOut = 64'(cur.tmr) >= TIMEOUT_CYCLES;
  // flow control applies while typing and during unload
  assign flowActive = cur.st inside {sbl_pkg::S_CMD, sbl_pkg::S_UL_RD,
    sbl_pkg::S_UL_TX, sbl_pkg::S_UL_SUM};
  // hex digit value
  function automatic logic [3:0] hexVal(input logic [7:0] ch);
    logic [7:0] v;
    v = 8'h00;
    if (ch >= sbl_pkg::CH_0 && ch <= sbl_pkg::CH_9) begin
      v = ch - sbl_pkg::CH_0;
    end else if (ch >= sbl_pkg::CH_A && ch <= sbl_pkg::CH_F) begin
      v = ch - sbl_pkg::CH_A + sbl_pkg::HEX_TEN;
    end else if (ch >= sbl_pkg::CH_AL && ch <= sbl_pkg::CH_FL) begin
      v = ch - sbl_pkg::CH_AL + sbl_pkg::HEX_TEN;
    end
    return v[3:0];
  endfunction
  // error text then prompt text
  function automatic logic [7:0] msgByte(input logic [2:0] i);
    case (i)
      3'h0: return sbl_pkg::CH_Q;
      3'h1: return sbl_pkg::CH_CR;
      3'h2: return sbl_pkg::CH_LF;
      default: return sbl_pkg::CH_GT;
    endcase
  endfunction
  // next state of the engine
  always_comb begin
    next_cur = cur;
    pop = 1'b0;
    bufWr = 1'b0;
    flowCancel = 1'b0;
    c = lineBuf[cur.idx[4:0]];
    s = cur.sum + fByte.data;
    if (cur.txValid && txReady) begin // transmitter took the byte
      next_cur.txValid = 1'b0;
    end
    // checksum and load data waiting states count toward timeout
    if (cur.st inside {sbl_pkg::S_CKSUM, sbl_pkg::S_LD_RX, sbl_pkg::S_LD_SUM}) begin
      next_cur.tmr = cur.tmr + 1'b1;
    end
    case (cur.st)
      // collect and echo the typed line
      sbl_pkg::S_CMD: begin
        if (fValid && !cur.txValid) begin
          pop = 1'b1;
          if (fByte.data == sbl_pkg::CH_CR) begin
            flowCancel = 1'b1;
            next_cur.txValid = 1'b1;
            next_cur.txData = fByte.data;
            next_cur.idx = '0;
            next_cur.field = '0;
            next_cur.sum = '0;
            next_cur.cnt = '0;
            next_cur.mem.addr = '0;
            next_cur.isX = 1'b0;
            next_cur.comment = 1'b0;
            next_cur.st = sbl_pkg::S_PARSE;
          end else if (fByte.data == sbl_pkg::CH_RUB) begin
            if (cur.len != '0) begin // rubout drops last character, never summed
              next_cur.len = cur.len - 1'b1;
            end
          end else if (cur.len < 6'(sbl_pkg::LINE_MAX)) begin
            bufWr = 1'b1;
            next_cur.len = cur.len + 1'b1;
            next_cur.txValid = 1'b1;
            next_cur.txData = fByte.data;
          end
        end
      end
      // walk the stored line: sum and hex arguments
      sbl_pkg::S_PARSE: begin
        if (cur.idx == cur.len || cur.comment) begin
          next_cur.len = '0;
          next_cur.tmr = '0;
          if (cur.isX) begin
            next_cur.st = sbl_pkg::S_CKSUM;
          end else begin
            next_cur.goData = 1'b0;
            next_cur.msgIdx = sbl_pkg::MSG_PROMPT;
            next_cur.st = sbl_pkg::S_MSG;
          end
        end else begin
          next_cur.idx = cur.idx + 1'b1;
          if (c == sbl_pkg::CH_BANG) begin
            next_cur.comment = 1'b1;
          end else begin
            next_cur.sum = cur.sum + c;
            if (cur.idx == '0) begin
              next_cur.isX = (c == sbl_pkg::CH_X) || (c == sbl_pkg::CH_XL);
            end else if (c == sbl_pkg::CH_SP) begin
              next_cur.field = (cur.field == 2'h3) ? cur.field : cur.field + 2'h1;
            end else if (cur.field == 2'h1) begin
              next_cur.mem.addr = {cur.mem.addr[27:0], hexVal(c)};
            end else if (cur.field == 2'h2) begin
              next_cur.cnt = {cur.cnt[27:0], hexVal(c)};
            end
          end
        end
      end
      // command checksum byte, not echoed
      sbl_pkg::S_CKSUM: begin
        next_cur.goData = 1'b0;
        if (timedOut) begin
          next_cur.msgIdx = sbl_pkg::MSG_ERR;
          next_cur.st = sbl_pkg::S_MSG;
        end else if (fValid) begin
          pop = 1'b1;
          next_cur.goData = s == 8'h00;
          next_cur.msgIdx = (s == 8'h00) ? sbl_pkg::MSG_PROMPT : sbl_pkg::MSG_ERR;
          next_cur.st = sbl_pkg::S_MSG;
        end
      end
      // send error and/or prompt text
      sbl_pkg::S_MSG: begin
        if (!cur.txValid) begin
          next_cur.txValid = 1'b1;
          next_cur.txData = msgByte(cur.msgIdx);
          next_cur.msgIdx = cur.msgIdx + 1'b1;
          if (cur.msgIdx == sbl_pkg::MSG_LAST) begin
            next_cur.sum = '0;
            next_cur.tmr = '0;
            next_cur.err = 1'b0;
            next_cur.goData = 1'b0;
            if (!cur.goData) begin
              next_cur.st = sbl_pkg::S_CMD;
            end else if (cur.cnt[sbl_pkg::DIR_BIT]) begin
              next_cur.st = sbl_pkg::S_UL_RD;
            end else begin
              next_cur.st = sbl_pkg::S_LD_RX;
            end
          end
        end
      end
      // load: take a raw data byte
      sbl_pkg::S_LD_RX: begin
        if (cur.cnt[sbl_pkg::DIR_BIT-1:0] == '0) begin
          next_cur.st = sbl_pkg::S_LD_SUM;
        end else if (timedOut) begin
          next_cur.msgIdx = sbl_pkg::MSG_ERR;
          next_cur.st = sbl_pkg::S_MSG;
        end else if (fValid) begin
          pop = 1'b1;
          next_cur.sum = s;
          next_cur.err = cur.err | fByte.err;
          next_cur.mem.req = 1'b1;
          next_cur.mem.write = 1'b1;
          next_cur.mem.wdata = fByte.data;
          next_cur.st = sbl_pkg::S_LD_WR;
        end
      end
      // load: wait for the memory write
      sbl_pkg::S_LD_WR: begin
        if (memAck) begin
          next_cur.mem.req = 1'b0;
          next_cur.err = cur.err | memErr;
          next_cur.mem.addr = cur.mem.addr + 1'b1;
          next_cur.cnt = cur.cnt - 1'b1;
          next_cur.tmr = '0;
          next_cur.st = sbl_pkg::S_LD_RX;
        end
      end
      // load: data checksum, then report
      sbl_pkg::S_LD_SUM: begin
        if (timedOut) begin
          next_cur.msgIdx = sbl_pkg::MSG_ERR;
          next_cur.st = sbl_pkg::S_MSG;
        end else if (fValid) begin
          pop = 1'b1;
          next_cur.msgIdx = (cur.err || fByte.err || s != 8'h00) ?
            sbl_pkg::MSG_ERR : sbl_pkg::MSG_PROMPT;
          next_cur.st = sbl_pkg::S_MSG;
        end
      end
      // unload: read the next byte
      sbl_pkg::S_UL_RD: begin
        if (cur.cnt[sbl_pkg::DIR_BIT-1:0] == '0) begin
          next_cur.st = sbl_pkg::S_UL_SUM;
        end else if (cur.mem.req && memAck) begin
          next_cur.mem.req = 1'b0;
          next_cur.hold = memRdata;
          next_cur.err = cur.err | memErr;
          next_cur.st = sbl_pkg::S_UL_TX;
        end else begin
          next_cur.mem.req = 1'b1;
          next_cur.mem.write = 1'b0;
        end
      end
      // unload: send the byte unless the host holds the line
      sbl_pkg::S_UL_TX: begin
        if (!cur.txValid && !lineHold) begin
          next_cur.txValid = 1'b1;
          next_cur.txData = cur.hold;
          next_cur.sum = cur.sum + cur.hold;
          next_cur.mem.addr = cur.mem.addr + 1'b1;
          next_cur.cnt = cur.cnt - 1'b1;
          next_cur.st = sbl_pkg::S_UL_RD;
        end
      end
      // unload: negated sum, then prompt
      sbl_pkg::S_UL_SUM: begin
        if (!cur.txValid && !lineHold) begin
          next_cur.txValid = 1'b1;
          next_cur.txData = 8'h00 - cur.sum;
          next_cur.msgIdx = cur.err ? sbl_pkg::MSG_ERR : sbl_pkg::MSG_PROMPT;
          next_cur.st = sbl_pkg::S_MSG;
        end
      end
      default: begin
        next_cur.st = sbl_pkg::S_CMD;
      end
    endcase
  end
  // state register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  // line buffer store
  always_ff @(posedge clk_sys) begin
    if (bufWr) begin
      lineBuf[cur.len[4:0]] <= fByte.data;
    end
  end
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence sCrTaken;
    cur.st == sbl_pkg::S_CMD && pop && fByte.data == sbl_pkg::CH_CR;
  endsequence
  sequence sMsgDone;
    cur.st == sbl_pkg::S_MSG && !cur.txValid && cur.msgIdx == sbl_pkg::MSG_LAST;
  endsequence
  AST_CR_CANCEL: assert property (sCrTaken |-> flowCancel ##1 cur.st == sbl_pkg::S_PARSE)
    else $error("carriage return did not cancel flow control");
  AST_LOAD_DIR: assert property (sMsgDone ##0 (cur.goData && !cur.cnt[sbl_pkg::DIR_BIT])
    |=> cur.st == sbl_pkg::S_LD_RX) else $error("load not entered");
  AST_UNLOAD_DIR: assert property (sMsgDone ##0 (cur.goData && cur.cnt[sbl_pkg::DIR_BIT])
    |=> cur.st == sbl_pkg::S_UL_RD) else $error("unload not entered");
  AST_COUNT_STEP: assert property (cur.st == sbl_pkg::S_LD_WR && memAck
    |=> cur.cnt == $past(cur.cnt) - 1 && cur.mem.addr == $past(cur.mem.addr) + 1)
    else $error("count or address did not step");
  AST_BAD_CKSUM: assert property (cur.st == sbl_pkg::S_CKSUM && pop && s != 8'h00
    |=> cur.st == sbl_pkg::S_MSG && cur.msgIdx == sbl_pkg::MSG_ERR && !cur.goData)
    else $error("bad command checksum not reported");
  AST_NO_ECHO: assert property ($rose(cur.txValid) |-> $past(cur.st) inside
    {sbl_pkg::S_CMD, sbl_pkg::S_MSG, sbl_pkg::S_UL_TX, sbl_pkg::S_UL_SUM})
    else $error("byte sent during receive phase");
  AST_TIMEOUT: assert property (cur.st == sbl_pkg::S_LD_SUM && timedOut
    |=> cur.st == sbl_pkg::S_MSG && cur.msgIdx == sbl_pkg::MSG_ERR)
    else $error("timeout did not abort");
  AST_UL_HOLD: assert property (cur.st == sbl_pkg::S_UL_TX && lineHold
    |=> cur.st == sbl_pkg::S_UL_TX) else $error("unload ignored line hold");
  AST_UL_SUM: assert property (cur.st == sbl_pkg::S_UL_SUM && !cur.txValid && !lineHold
    |=> cur.txValid && cur.txData == 8'h00 - $past(cur.sum))
    else $error("unload checksum wrong");
endmodule

// [dv/sbl_host_model.sv]
// host partner: transmit sink, line control and byte memory responder
module sbl_host_model (
  input wire logic clk_sys,
  input wire sbl_pkg::sbl_mem_type memOut,
  output logic txReady,
  output logic lineHold,
  output logic memAck,
  output logic memErr,
  output logic [7:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int]; // byte memory, preloaded by the bench
  int delay = 1; // cycles before each acknowledge
  int errAddr = -1; // address that answers with a memory error
  int waitCnt = 0; // cycles the pending request has waited
  // quiet outputs at time zero
  initial begin
    txReady = 1'b0;
    lineHold = 1'b0;
    memAck = 1'b0;
    memErr = 1'b0;
    memRdata = 8'h00;
  end
  // sink stalls at random; host pauses the line now and then
  always @(negedge clk_sys) begin
    txReady <= ($urandom % 4) != 0;
    lineHold <= ($urandom % 8) == 0;
  end
  // one-cycle acknowledge after a chosen delay; read data not held after it
  always @(negedge clk_sys) begin
    if (memAck) begin
      memAck <= 1'b0;
      memErr <= 1'b0;
      memRdata <= ~memRdata;
    end else if (memOut.req === 1'b1) begin
      if (waitCnt >= delay) begin
        waitCnt <= 0;
        memAck <= 1'b1;
        memErr <= int'(memOut.addr) == errAddr;
        if (memOut.write) mem[int'(memOut.addr)] = memOut.wdata;
        else memRdata <= mem.exists(int'(memOut.addr)) ? mem[int'(memOut.addr)] : 8'h5a;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule

// [dv/sbl_engine_tb.sv]
// self-checking bench for the serial binary load/unload engine
module sbl_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint TMO = 200; // shortened load timeout
  logic clk_sys = 1'b0; // system clock
  logic reset_n = 1'b0; // sync reset, active low
  logic rxValid = 1'b0; // host byte offered
  sbl_pkg::sbl_rx_type rxByte = '0; // host byte and line error
  logic rxReady, txValid, txReady, lineHold, flowCancel, flowActive, memAck, memErr;
  logic [7:0] txData, memRdata;
  sbl_pkg::sbl_mem_type memOut;
  logic [7:0] expQ [$]; // expected transmit bytes, oldest first
  logic [7:0] dat [$]; // data of the current load
  int num_errors = 0;
  int check_count = 0;
  int crCount = 0; // carriage returns sent
  int cancelCount = 0; // flow-cancel pulses seen
  bit sawFull = 1'b0; // fifo refused a byte

  sbl_engine #(.TIMEOUT_CYCLES(TMO), .DEPTH(8)) sbl_engine_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .rxValid(rxValid), .rxReady(rxReady), .rxByte(rxByte),
    .txValid(txValid), .txReady(txReady), .txData(txData), .lineHold(lineHold),
    .flowCancel(flowCancel), .flowActive(flowActive), .memOut(memOut), .memAck(memAck),
    .memErr(memErr), .memRdata(memRdata));
  sbl_host_model host_inst (.clk_sys(clk_sys), .memOut(memOut), .txReady(txReady),
    .lineHold(lineHold), .memAck(memAck), .memErr(memErr), .memRdata(memRdata));

  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // watcher: every transmitted byte against the oldest note
  always @(posedge clk_sys) begin
    if (reset_n && txValid === 1'b1 && txReady === 1'b1) begin
      if (expQ.size() == 0) begin
        num_errors++;
        $display("MISMATCH %0t unexpected byte %h", $time, txData);
      end else begin
        check(txData, expQ.pop_front(), "tx byte");
      end
    end
    if (flowCancel === 1'b1) cancelCount++;
    if (rxValid && rxReady === 1'b0) sawFull = 1'b1;
  end

  task automatic ex(input string s);
    foreach (s[i]) expQ.push_back(s[i]);
  endtask

  // one host byte, held until the fifo takes it
  task automatic send(input logic [7:0] b, input logic e = 1'b0);
    int n;
    n = 0;
    @(negedge clk_sys);
    rxValid = 1'b1;
    rxByte = '{err: e, data: b};
    while (rxReady !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    rxValid = 1'b0;
    rxByte = ~rxByte; // released lines do not hold the byte
  endtask

  // wait for all noted output, then watch for strays
  task automatic drain(input string t);
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    if (expQ.size() != 0) begin
      num_errors++;
      $display("MISMATCH %0t output missing", $time);
      expQ.delete();
    end
    repeat (30) @(negedge clk_sys);
    $display("test %s done, mismatches %0d", t, num_errors);
  endtask

  // typed line with echo, then checksum good or off by one
  task automatic command(input string s, input bit good, input bit ck = 1'b1);
    logic [7:0] sum;
    logic [7:0] eff [$];
    foreach (s[i]) begin
      send(s[i]);
      if (s[i] == sbl_pkg::CH_RUB) begin
        void'(eff.pop_back());
      end else begin
        eff.push_back(s[i]);
        expQ.push_back(s[i]);
      end
    end
    send(sbl_pkg::CH_CR);
    expQ.push_back(sbl_pkg::CH_CR);
    crCount++;
    sum = 8'h00;
    foreach (eff[i]) sum += eff[i];
    if (ck) begin
      send(good ? -sum : 8'h01 - sum);
      if (good) begin
        ex(">>>");
      end else begin
        ex("?\015\n>>>");
      end
    end
  endtask

  // load n bytes; first byte is a line-control code taken as data
  task automatic load(input int addr, input int n, input bit bad, input int errAt, string t);
    logic [7:0] sum;
    bit fail;
    fail = bad || errAt >= 0 || (host_inst.errAddr >= addr && host_inst.errAddr < addr + n);
    dat.delete();
    sum = 8'h00;
    command($sformatf("X %0h5\177 %0h", addr, n), 1'b1);
    for (int i = 0; i < n; i++) begin
      dat.push_back(i == 0 ? 8'h13 : 8'($urandom));
      sum += dat[i];
      send(dat[i], i == errAt);
    end
    if (n > 0) check({7'h00, flowActive}, 8'h00, "flow control in load");
    send(bad ? 8'h01 - sum : -sum);
    if (fail) begin
      ex("?\015\n>>>");
    end else begin
      ex(">>>");
    end
    drain(t);
    if (!fail) foreach (dat[i]) check(host_inst.mem[addr + i], dat[i], "mem");
  endtask

  // unload n preloaded bytes, then negated sum
  task automatic unload(input int addr, input int n, string t);
    logic [7:0] sum;
    bit fail;
    fail = host_inst.errAddr >= addr && host_inst.errAddr < addr + n;
    sum = 8'h00;
    for (int i = 0; i < n; i++) if (!fail) host_inst.mem[addr + i] = 8'($urandom);
    command($sformatf("X %0h %0h", addr, 32'h8000_0000 | n), 1'b1);
    for (int i = 0; i < n; i++) begin
      expQ.push_back(host_inst.mem[addr + i]);
      sum += host_inst.mem[addr + i];
    end
    expQ.push_back(-sum);
    if (fail) begin
      ex("?\015\n>>>");
    end else begin
      ex(">>>");
    end
    drain(t);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog on a hang
  initial begin
    #600_000;
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial begin
    void'($urandom(72085));
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    load(32'h100 + ($urandom % 64), 6, 1'b0, -1, "load");
    unload(32'h2000, 9, "unload");
    command("X 200 80000004", 1'b0);
    drain("bad command checksum");
    command("X 300 4", 1'b1, 1'b0);
    ex("?\015\n>>>");
    drain("checksum timeout");
    command("!X 5 80000001", 1'b1, 1'b0);
    ex(">>>");
    drain("comment line");
    // load whose data checksum never comes
    command("X 800 2", 1'b1);
    send(8'h11);
    send(8'h22);
    ex("?\015\n>>>");
    drain("data checksum timeout");
    host_inst.delay = 30;
    load(32'h400, 12, 1'b1, -1, "bad data checksum, slow memory");
    check({7'h00, sawFull}, 8'h01, "fifo refused");
    host_inst.delay = 1;
    load(32'h700, 5, 1'b0, 2, "line error");
    host_inst.errAddr = 32'h502;
    load(32'h500, 4, 1'b0, -1, "memory error on load");
    unload(32'h500, 4, "memory error on unload");
    host_inst.errAddr = -1;
    load(32'h600, 0, 1'b0, -1, "empty load");
    check(8'(cancelCount), 8'(crCount), "flow cancel pulses");
    end_sim();
  end
endmodule
